// File: rtl/fss_consts.vh
// Constants for the floppy seek and sector sequencer.
// Assumes a single system clock whose rate is given in kHz below.
`ifndef FSS_CONSTS_VH
`define FSS_CONSTS_VH

`define FSS_CLK_KHZ 10000
// Step intervals in ms, indexed by the step-rate field
`define FSS_STEP_R0_MS 6
`define FSS_STEP_R1_MS 12
`define FSS_STEP_R2_MS 2
`define FSS_STEP_R3_MS 3
`define FSS_SETTLE_E_MS 15
`define FSS_SETTLE_V_MS 30
`define FSS_PULSE_DD_US 4
`define FSS_PULSE_SD_US 8
`define FSS_DIR_SETUP_US 24
`define FSS_RESTORE_MAX 8'hFF
// Byte windows and counts, single / double density
`define FSS_DAM_WIN_SD 11'h01E
`define FSS_DAM_WIN_DD 11'h02B
`define FSS_WR_GAP_SD 11'h00B
`define FSS_WR_GAP_DD 11'h016
`define FSS_WR_ZERO_SD 11'h006
`define FSS_WR_ZERO_DD 11'h00C
// Revolution limits
`define FSS_REV_ID 3'h4
`define FSS_REV_DAM 3'h5
`define FSS_REV_VERIFY 3'h5
// Command bit positions
`define FSS_BIT_VERIFY 2
`define FSS_BIT_UPDATE 4
`define FSS_BIT_MULTI 4
`define FSS_BIT_SETTLE 2
`define FSS_BIT_DELMARK 0
// Command opcodes in bits 7..4 or 7..5
`define FSS_OP_RESTORE 4'h0
`define FSS_OP_SEEK 4'h1
`define FSS_OP_READ 3'h4
`define FSS_OP_WRITE 3'h5

`endif

// File: rtl/fss_sequencer.v
// Seek, step and sector read/write sequencer of a floppy disk controller.
// Assumes byte-level disk events (ID fields, marks, bytes, byte ticks)
// come from a data separator on the same clock; drive sense pins are async.
// Functional notes
// - Restore: step outward until track zero sensed, then clear track, interrupt.
// - Restore gives up after 255 pulses; seek error if verify flag set.
// - Restore with verify checks head position after reaching track zero.
// - Seek steps toward data register, updating track, until equal; verify; interrupt.
// - Step: one pulse same direction as last, optional update, delay, verify.
// - Step-in: one inward pulse, optional increment, delay, verify, interrupt.
// - Step-out: one outward pulse, optional decrement, delay, verify, interrupt.
// - Sector command sets busy; optional settle delay before searching.
// - ID field must match track, sector and have good CRC to proceed.
// - No matching ID within revolution limit sets record-not-found, interrupts.
// - Multi-sector increments sector register and continues; single ends after one.
// - Read needs data mark within 30/43 bytes; five revolutions else not found.
// - Read bytes go to holding register with request; overrun sets lost data.
// - Data CRC failure sets CRC error and ends command.
// - Read records deleted mark type in status.
// - Write: request, count 11/22 bytes, gate only if serviced, else lost data.
// - After gate, write 6/12 zero bytes then the data mark.
// - Command bit 0 selects deleted or normal written mark.
// - Step-rate field: 6, 12, 2, 3 ms.
// - Direction high inward, low outward, valid 24 us before pulse.
// - Step pulse 4 us double density, 8 us single density.
// - Host read or write of holding register clears data request.
`timescale 1ns/1ps
`include "fss_consts.vh"

module fss_sequencer #(
  parameter [18:0] STEP_R0_CYC = `FSS_STEP_R0_MS * `FSS_CLK_KHZ,
  parameter [18:0] STEP_R1_CYC = `FSS_STEP_R1_MS * `FSS_CLK_KHZ,
  parameter [18:0] STEP_R2_CYC = `FSS_STEP_R2_MS * `FSS_CLK_KHZ,
  parameter [18:0] STEP_R3_CYC = `FSS_STEP_R3_MS * `FSS_CLK_KHZ,
  parameter [18:0] SETTLE_E_CYC = `FSS_SETTLE_E_MS * `FSS_CLK_KHZ,
  parameter [18:0] SETTLE_V_CYC = `FSS_SETTLE_V_MS * `FSS_CLK_KHZ,
  parameter [10:0] SECTOR_BYTES = 11'h100
) (
  input wire clock,
  input wire reset,
  input wire single_density,
  input wire [7:0] host_data,
  input wire host_wr_command,
  input wire host_wr_track,
  input wire host_wr_sector,
  input wire host_wr_data,
  input wire host_rd_data,
  input wire host_rd_status,
  input wire track_zero_sense_n,
  input wire index_n,
  input wire id_valid,
  input wire [7:0] id_track,
  input wire [7:0] id_sector,
  input wire id_crc_ok,
  input wire byte_tick,
  input wire mark_found,
  input wire mark_deleted,
  input wire read_valid,
  input wire [7:0] read_byte,
  input wire data_crc_end,
  input wire data_crc_ok,
  output reg [7:0] track_reg,
  output reg [7:0] sector_reg,
  output reg [7:0] data_holding_register,
  output reg busy,
  output reg data_request,
  output reg interrupt_request,
  output reg seek_error,
  output reg record_not_found,
  output reg crc_error,
  output reg lost_data,
  output reg deleted_mark,
  output reg step_pulse,
  output reg step_direction,
  output reg write_gate,
  output reg [7:0] write_byte,
  output reg write_strobe,
  output reg write_mark,
  output reg write_mark_deleted
);

  localparam [18:0] PULSE_DD = `FSS_PULSE_DD_US * `FSS_CLK_KHZ / 1000;
  localparam [18:0] PULSE_SD = `FSS_PULSE_SD_US * `FSS_CLK_KHZ / 1000;
  localparam [18:0] DIR_SETUP = `FSS_DIR_SETUP_US * `FSS_CLK_KHZ / 1000;

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_DIR = 4'h1;
  localparam [3:0] S_PULSE = 4'h2;
  localparam [3:0] S_RATE = 4'h3;
  localparam [3:0] S_CHECK = 4'h4;
  localparam [3:0] S_VSET = 4'h5;
  localparam [3:0] S_VER = 4'h6;
  localparam [3:0] S_ESET = 4'h7;
  localparam [3:0] S_SRCH = 4'h8;
  localparam [3:0] S_DAM = 4'h9;
  localparam [3:0] S_RD = 4'hA;
  localparam [3:0] S_WGAP = 4'hB;
  localparam [3:0] S_WZERO = 4'hC;
  localparam [3:0] S_WMARK = 4'hD;
  localparam [3:0] S_WDATA = 4'hE;
  localparam [3:0] S_DONE = 4'hF;

  reg [3:0] state;
  reg [7:0] cmd;
  reg [18:0] timer;
  reg [10:0] count;
  reg [7:0] steps;
  reg [2:0] revs;
  reg mark_seen;
  reg tz_s1, tz_s2, tz_s3, tz_level;
  reg ix_s1, ix_s2, ix_s3, ix_level, ix_prev;

  wire is_restore = (cmd[7:4] == `FSS_OP_RESTORE);
  wire is_seek = (cmd[7:4] == `FSS_OP_SEEK);
  wire is_write = (cmd[7:5] == `FSS_OP_WRITE);
  wire verify = cmd[`FSS_BIT_VERIFY];
  wire index_edge = ix_prev & ~ix_level;
  wire host_took = host_rd_data | host_wr_data;

  // Step interval for the step-rate field
  function [18:0] step_cycles;
    input [1:0] rate;
    begin
      case (rate)
        2'h0: step_cycles = STEP_R0_CYC;
        2'h1: step_cycles = STEP_R1_CYC;
        2'h2: step_cycles = STEP_R2_CYC;
        default: step_cycles = STEP_R3_CYC;
      endcase
    end
  endfunction

  // Pick single or double density figure
  function [10:0] by_density;
    input sd;
    input [10:0] sd_val;
    input [10:0] dd_val;
    begin
      by_density = sd ? sd_val : dd_val;
    end
  endfunction

  // Drive pins: three flops, a change counts when stages two and three agree
  always @(posedge clock) begin
    if (reset) begin
      tz_s1 <= 1'b1;
      tz_s2 <= 1'b1;
      tz_s3 <= 1'b1;
      tz_level <= 1'b1;
      ix_s1 <= 1'b1;
      ix_s2 <= 1'b1;
      ix_s3 <= 1'b1;
      ix_level <= 1'b1;
      ix_prev <= 1'b1;
    end else begin
      tz_s1 <= track_zero_sense_n;
      tz_s2 <= tz_s1;
      tz_s3 <= tz_s2;
      if (tz_s2 == tz_s3) tz_level <= tz_s3;
      ix_s1 <= index_n;
      ix_s2 <= ix_s1;
      ix_s3 <= ix_s2;
      if (ix_s2 == ix_s3) ix_level <= ix_s3;
      ix_prev <= ix_level;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      timer <= 19'h00000;
      count <= 11'h000;
      steps <= 8'h00;
      revs <= 3'h0;
      mark_seen <= 1'b0;
      track_reg <= 8'h00;
      sector_reg <= 8'h00;
      data_holding_register <= 8'h00;
      busy <= 1'b0;
      data_request <= 1'b0;
      interrupt_request <= 1'b0;
      seek_error <= 1'b0;
      record_not_found <= 1'b0;
      crc_error <= 1'b0;
      lost_data <= 1'b0;
      deleted_mark <= 1'b0;
      step_pulse <= 1'b0;
      step_direction <= 1'b0;
      write_gate <= 1'b0;
      write_byte <= 8'h00;
      write_strobe <= 1'b0;
      write_mark <= 1'b0;
      write_mark_deleted <= 1'b0;
    end else begin
      write_strobe <= 1'b0;
      write_mark <= 1'b0;
      // Clears first; any set below in the same cycle wins
      if (host_took) data_request <= 1'b0;
      if (host_wr_data) data_holding_register <= host_data;
      if (host_rd_status || host_wr_command) interrupt_request <= 1'b0;
      if (timer != 19'h00000) timer <= timer - 19'h00001;
      if (index_edge && revs != 3'h7) revs <= revs + 3'h1;
      case (state)
        S_IDLE: begin
          if (host_wr_track) track_reg <= host_data;
          if (host_wr_sector) sector_reg <= host_data;
          if (host_wr_command && !host_data[7]) begin
            cmd <= host_data;
            busy <= 1'b1;
            seek_error <= 1'b0;
            crc_error <= 1'b0;
            steps <= 8'h00;
            if (host_data[6:5] == 2'h0) begin
              state <= S_CHECK;
            end else begin
              if (host_data[6]) step_direction <= ~host_data[5];
              timer <= DIR_SETUP;
              state <= S_DIR;
            end
          end else if (host_wr_command && host_data[7:6] == 2'h2) begin
            cmd <= host_data;
            busy <= 1'b1;
            record_not_found <= 1'b0;
            crc_error <= 1'b0;
            lost_data <= 1'b0;
            deleted_mark <= 1'b0;
            revs <= 3'h0;
            mark_seen <= 1'b0;
            if (host_data[`FSS_BIT_SETTLE]) begin
              timer <= SETTLE_E_CYC;
              state <= S_ESET;
            end else begin
              state <= S_SRCH;
            end
          end
        end
        S_CHECK: begin
          if (is_restore) begin
            if (!tz_level) begin
              track_reg <= 8'h00;
              state <= verify ? S_VSET : S_DONE;
              timer <= SETTLE_V_CYC;
            end else if (steps == `FSS_RESTORE_MAX) begin
              seek_error <= verify;
              state <= S_DONE;
            end else begin
              step_direction <= 1'b0;
              timer <= DIR_SETUP;
              state <= S_DIR;
            end
          end else if (track_reg == data_holding_register) begin
            state <= verify ? S_VSET : S_DONE;
            timer <= SETTLE_V_CYC;
          end else begin
            step_direction <= (data_holding_register > track_reg);
            timer <= DIR_SETUP;
            state <= S_DIR;
          end
        end
        S_DIR: begin
          if (timer == 19'h00000) begin
            step_pulse <= 1'b1;
            steps <= steps + 8'h01;
            timer <= (single_density ? PULSE_SD : PULSE_DD) - 19'h00001;
            if (is_seek || (!is_restore && cmd[`FSS_BIT_UPDATE])) begin
              track_reg <= step_direction ? track_reg + 8'h01
                                          : track_reg - 8'h01;
            end
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (timer == 19'h00000) begin
            step_pulse <= 1'b0;
            timer <= step_cycles(cmd[1:0]);
            state <= S_RATE;
          end
        end
        S_RATE: begin
          if (timer == 19'h00000) begin
            if (is_restore || is_seek) begin
              state <= S_CHECK;
            end else begin
              timer <= SETTLE_V_CYC;
              state <= verify ? S_VSET : S_DONE;
            end
          end
        end
        S_VSET: begin
          if (timer == 19'h00000) begin
            revs <= 3'h0;
            state <= S_VER;
          end
        end
        S_VER: begin
          if (id_valid && id_track == track_reg && id_crc_ok) begin
            crc_error <= 1'b0;
            state <= S_DONE;
          end else if (revs >= `FSS_REV_VERIFY) begin
            seek_error <= 1'b1;
            state <= S_DONE;
          end else if (id_valid && id_track == track_reg) begin
            crc_error <= 1'b1;
          end
        end
        S_ESET: begin
          if (timer == 19'h00000) begin
            revs <= 3'h0;
            state <= S_SRCH;
          end
        end
        S_SRCH: begin
          write_gate <= 1'b0;
          if (revs >= (mark_seen ? `FSS_REV_DAM : `FSS_REV_ID)) begin
            record_not_found <= 1'b1;
            state <= S_DONE;
          end else if (id_valid && id_track == track_reg && id_sector == sector_reg
                       && id_crc_ok) begin
            mark_seen <= 1'b1;
            count <= 11'h000;
            if (is_write) begin
              data_request <= 1'b1;
              state <= S_WGAP;
            end else begin
              state <= S_DAM;
            end
          end
        end
        S_DAM: begin
          if (mark_found) begin
            deleted_mark <= mark_deleted;
            count <= 11'h000;
            state <= S_RD;
          end else if (byte_tick) begin
            count <= count + 11'h001;
            if (count + 11'h001 >= by_density(single_density, `FSS_DAM_WIN_SD,
                                              `FSS_DAM_WIN_DD)) begin
              state <= S_SRCH;
            end
          end
        end
        S_RD: begin
          if (read_valid) begin
            if (data_request && !host_rd_data) begin
              lost_data <= 1'b1;
            end else begin
              data_holding_register <= read_byte;
              data_request <= 1'b1;
            end
          end
          if (data_crc_end) begin
            if (!data_crc_ok) begin
              crc_error <= 1'b1;
              state <= S_DONE;
            end else if (cmd[`FSS_BIT_MULTI]) begin
              sector_reg <= sector_reg + 8'h01;
              revs <= 3'h0;
              mark_seen <= 1'b0;
              state <= S_SRCH;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_WGAP: begin
          if (byte_tick) begin
            count <= count + 11'h001;
            if (count + 11'h001 >= by_density(single_density, `FSS_WR_GAP_SD,
                                              `FSS_WR_GAP_DD)) begin
              count <= 11'h000;
              if (data_request && !host_wr_data) begin
                lost_data <= 1'b1;
                state <= S_DONE;
              end else begin
                write_gate <= 1'b1;
                state <= S_WZERO;
              end
            end
          end
        end
        S_WZERO: begin
          if (byte_tick) begin
            write_byte <= 8'h00;
            write_strobe <= 1'b1;
            count <= count + 11'h001;
            if (count + 11'h001 >= by_density(single_density, `FSS_WR_ZERO_SD,
                                              `FSS_WR_ZERO_DD)) begin
              state <= S_WMARK;
            end
          end
        end
        S_WMARK: begin
          if (byte_tick) begin
            write_mark <= 1'b1;
            write_mark_deleted <= cmd[`FSS_BIT_DELMARK];
            count <= 11'h000;
            state <= S_WDATA;
          end
        end
        S_WDATA: begin
          if (byte_tick) begin
            write_strobe <= 1'b1;
            if (data_request && !host_wr_data) begin
              write_byte <= 8'h00;
              lost_data <= 1'b1;
            end else begin
              write_byte <= host_wr_data ? host_data : data_holding_register;
            end
            count <= count + 11'h001;
            if (count + 11'h001 >= SECTOR_BYTES) begin
              // Gate stays up through the last byte and drops on the next cycle
              if (cmd[`FSS_BIT_MULTI]) begin
                sector_reg <= sector_reg + 8'h01;
                revs <= 3'h0;
                mark_seen <= 1'b0;
                state <= S_SRCH;
              end else begin
                state <= S_DONE;
              end
            end else begin
              data_request <= 1'b1;
            end
          end
        end
        S_DONE: begin
          busy <= 1'b0;
          write_gate <= 1'b0;
          step_pulse <= 1'b0;
          interrupt_request <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // fss_sequencer

// File: verif/fss_checker.sv
// Concurrent checks on the ports of the floppy seek and sector sequencer.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ps
module fss_checker (
  input wire clock,
  input wire reset,
  input wire single_density,
  input wire [7:0] host_data,
  input wire host_wr_command,
  input wire host_wr_data,
  input wire host_rd_data,
  input wire id_valid,
  input wire read_valid,
  input wire [7:0] track_reg,
  input wire busy,
  input wire data_request,
  input wire interrupt_request,
  input wire seek_error,
  input wire step_pulse,
  input wire step_direction,
  input wire write_gate,
  input wire write_strobe,
  input wire write_mark,
  input wire write_mark_deleted
);
  reg [7:0] hi_cnt;
  reg [7:0] dir_age;
  reg last_dir;
  reg [7:0] cmd;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Pulse length, direction age and the command last accepted
  always @(posedge clock) begin
    if (reset) begin
      hi_cnt <= 8'h00;
      dir_age <= 8'h00;
      last_dir <= 1'b0;
      cmd <= 8'h00;
    end else begin
      hi_cnt <= step_pulse ? hi_cnt + 8'h01 : 8'h00;
      last_dir <= step_direction;
      if (step_direction != last_dir) dir_age <= 8'h00;
      else if (dir_age != 8'hFF) dir_age <= dir_age + 8'h01;
      if (host_wr_command && !busy) cmd <= host_data;
    end
  end
  cmd_busy_a: assert property (host_wr_command && !busy && host_data < 8'hC0 |=> busy)
    else $error("command not taken");
  done_irq_a: assert property ($fell(busy) |-> interrupt_request)
    else $error("end without interrupt");
  restore_zero_a: assert property ($fell(busy) && cmd[7:4] == 4'h0 && !seek_error |-> track_reg == 8'h00)
    else $error("track not cleared");
  pulse_len_a: assert property ($fell(step_pulse) |-> hi_cnt == (single_density ? 8'h50 : 8'h28))
    else $error("step pulse width wrong");
  dir_setup_a: assert property ($rose(step_pulse) |-> dir_age >= 8'hEE)
    else $error("direction setup short");
  dir_hold_a: assert property (step_pulse |-> $stable(step_direction))
    else $error("direction moved in pulse");
  step_busy_a: assert property (step_pulse |-> busy)
    else $error("step while idle");
  gate_serviced_a: assert property ($rose(write_gate) |-> !data_request)
    else $error("gate with unserviced request");
  mark_kind_a: assert property (write_mark |-> write_gate && write_mark_deleted == cmd[0])
    else $error("mark kind wrong");
  drq_clear_a: assert property (data_request && (host_rd_data || host_wr_data) && !read_valid
    && !write_strobe && !id_valid |=> !data_request)
    else $error("request not cleared");
  cover property ($fell(step_pulse));
  cover property (write_mark);
  cover property ($rose(interrupt_request));
endmodule // fss_checker
bind fss_sequencer fss_checker chk (.clock, .reset, .single_density, .host_data, .host_wr_command,
  .host_wr_data, .host_rd_data, .id_valid, .read_valid, .track_reg, .busy, .data_request,
  .interrupt_request, .seek_error, .step_pulse, .step_direction, .write_gate, .write_strobe,
  .write_mark, .write_mark_deleted);

// File: verif/fss_drive_model.sv
// Drive and data separator model: head position, index and a four-sector track.
// Assumes events are one clock long, with byte ticks every eight clocks.
`timescale 1ns/1ps
module fss_drive_model (
  input wire clock,
  input wire reset,
  input wire step_pulse,
  input wire step_direction,
  output wire track_zero_sense_n,
  output wire index_n,
  output wire id_valid,
  output wire [7:0] id_track,
  output wire [7:0] id_sector,
  output wire id_crc_ok,
  output wire byte_tick,
  output wire mark_found,
  output wire mark_deleted,
  output wire read_valid,
  output wire [7:0] read_byte,
  output wire data_crc_end,
  output wire data_crc_ok
);
  reg [7:0] head;
  reg step_prev;
  reg [2:0] ph;
  reg [5:0] b;
  reg [1:0] s;
  reg rev;
  wire [2:0] sn = {1'b0, s} + 3'h1;
  wire [7:0] val = head + {1'b0, sn, 4'h0} + {4'h0, b[3:0] - 4'h4};
  wire [7:0] noise = {ph, ph, ph[1:0]};
  assign byte_tick = ph == 3'h0;
  assign id_valid = byte_tick && b == 6'h00;
  assign id_track = id_valid ? head : ~head;
  assign id_sector = id_valid ? {5'h00, sn} : noise;
  // Sector four ID fails its CRC on every other revolution
  assign id_crc_ok = !(s == 2'h3 && rev);
  assign mark_found = byte_tick && b == 6'h02;
  assign mark_deleted = s == 2'h1;
  assign read_valid = byte_tick && b >= 6'h04 && b < 6'h08;
  assign read_byte = read_valid ? val : noise;
  assign data_crc_end = byte_tick && b == 6'h08;
  assign data_crc_ok = s != 2'h2;
  assign index_n = !(s == 2'h0 && b == 6'h3F);
  assign track_zero_sense_n = head != 8'h00;
  always @(posedge clock) begin
    if (reset) begin
      head <= 8'h05;
      step_prev <= 1'b0;
      ph <= 3'h0;
      b <= 6'h00;
      s <= 2'h0;
      rev <= 1'b0;
    end else begin
      step_prev <= step_pulse;
      // Head moves one track on each step rising edge
      if (step_pulse && !step_prev) head <= step_direction ? head + 8'h01 : head - 8'h01;
      ph <= ph + 3'h1;
      if (ph == 3'h7) b <= b + 6'h01;
      if (ph == 3'h7 && b == 6'h3F) s <= s + 2'h1;
      if (ph == 3'h7 && b == 6'h3F && s == 2'h3) rev <= ~rev;
    end
  end
endmodule // fss_drive_model

// File: verif/test_floppy_seek_and_sector_sequencer.sv
// Self-checking bench: host driver, host responder and an output monitor.
// Assumes the drive model supplies pins and disk events; double density except odd passes of the step loop, which run single density.
`timescale 1ns/1ps
module test_floppy_seek_and_sector_sequencer;
  reg clock, reset, single_density, host_wr_command, host_wr_track, host_wr_sector;
  reg host_wr_data, host_rd_data, host_rd_status, host_on, mode_wr, marked, irq_prev;
  reg [7:0] host_data, tgt, zc, k;
  reg [2:0] r;
  integer num_errors, num_checks;
  reg [12:0] end_q[$];
  reg [12:0] data_q[$];
  reg [7:0] wr_src[$];
  wire track_zero_sense_n, index_n, id_valid, id_crc_ok, byte_tick, mark_found, mark_deleted;
  wire read_valid, data_crc_end, data_crc_ok, busy, data_request, interrupt_request, seek_error;
  wire record_not_found, crc_error, lost_data, deleted_mark, step_pulse, step_direction;
  wire write_gate, write_strobe, write_mark, write_mark_deleted;
  wire [7:0] id_track, id_sector, read_byte, track_reg, sector_reg, data_holding_register, write_byte;
  fss_sequencer #(.STEP_R0_CYC(19'h32), .STEP_R1_CYC(19'h3C), .STEP_R2_CYC(19'h14),
    .STEP_R3_CYC(19'h1E), .SETTLE_E_CYC(19'h64), .SETTLE_V_CYC(19'h64), .SECTOR_BYTES(11'h004))
  DUT (.clock, .reset, .single_density, .host_data, .host_wr_command, .host_wr_track,
    .host_wr_sector, .host_wr_data, .host_rd_data, .host_rd_status, .track_zero_sense_n, .index_n,
    .id_valid, .id_track, .id_sector, .id_crc_ok, .byte_tick, .mark_found, .mark_deleted,
    .read_valid, .read_byte, .data_crc_end, .data_crc_ok, .track_reg, .sector_reg,
    .data_holding_register, .busy, .data_request, .interrupt_request, .seek_error,
    .record_not_found, .crc_error, .lost_data, .deleted_mark, .step_pulse, .step_direction,
    .write_gate, .write_byte, .write_strobe, .write_mark, .write_mark_deleted);
  fss_drive_model drive (.clock, .reset, .step_pulse, .step_direction, .track_zero_sense_n,
    .index_n, .id_valid, .id_track, .id_sector, .id_crc_ok, .byte_tick, .mark_found,
    .mark_deleted, .read_valid, .read_byte, .data_crc_end, .data_crc_ok);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task check(input [12:0] got, input [12:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task hwr(input [1:0] w, input [7:0] d);
    begin
      @(posedge clock);
      #1 host_data = d;
      host_wr_command = w == 2'h0;
      host_wr_track = w == 2'h1;
      host_wr_sector = w == 2'h2;
      host_wr_data = w == 2'h3;
      @(posedge clock);
      #1 host_wr_command = 1'b0;
      host_wr_track = 1'b0;
      host_wr_sector = 1'b0;
      host_wr_data = 1'b0;
    end
  endtask
  // Issue a command, note the expected ending, wait for it, then read status
  task run(input [7:0] c, input [7:0] t, input [4:0] st);
    integer n;
    begin
      end_q.push_back({t, st});
      hwr(2'h0, c);
      n = 0;
      while (interrupt_request !== 1'b1 && n < 20000) begin
        @(posedge clock);
        n = n + 1;
      end
      check({12'h000, interrupt_request}, 13'h0001);
      @(posedge clock);
      #1 host_rd_status = 1'b1;
      @(posedge clock);
      #1 host_rd_status = 1'b0;
    end
  endtask
  task exp_sec(input [3:0] sn);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) data_q.push_back({5'h00, tgt + {sn, 4'h0} + i[7:0]});
    end
  endtask
  // Host responder: reads or loads the holding register on each request
  always @(posedge clock) begin
    if (!reset && host_on && data_request === 1'b1) begin
      if (mode_wr) begin
        #1 host_data = wr_src.pop_front();
        host_wr_data = 1'b1;
      end else begin
        check({5'h00, data_holding_register}, data_q.pop_front());
        #1 host_rd_data = 1'b1;
      end
      @(posedge clock);
      #1 host_rd_data = 1'b0;
      host_wr_data = 1'b0;
    end
  end
  // Monitor: command endings, written mark and written bytes
  always @(posedge clock) begin
    if (reset) begin
      irq_prev = 1'b0;
      marked = 1'b0;
      zc = 8'h00;
    end else begin
      if (interrupt_request === 1'b1 && !irq_prev) check({track_reg, seek_error, record_not_found,
        crc_error, lost_data, deleted_mark}, end_q.pop_front());
      irq_prev = interrupt_request;
      if (write_gate && write_strobe && marked) check({5'h00, write_byte}, data_q.pop_front());
      else if (write_gate && write_strobe) zc = zc + 8'h01;
      if (write_mark) begin
        check({4'h0, write_mark_deleted, zc}, data_q.pop_front());
        marked = 1'b1;
      end
      if (!write_gate) begin
        marked = 1'b0;
        zc = 8'h00;
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    num_errors = num_errors + 1;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    {reset, single_density, host_wr_track, host_on, mode_wr} = 5'h12;
    {host_wr_command, host_wr_sector, host_wr_data, host_rd_data, host_rd_status} = 5'h00;
    host_data = 8'h00;
    num_errors = 0;
    num_checks = 0;
    k = $urandom(32'h5410FFF4);
    repeat (16) @(posedge clock);
    #1 reset = 1'b0;
    repeat (4) @(posedge clock);
    hwr(2'h1, k);
    run(8'h06, 8'h00, 5'h00);
    tgt = 8'h02 + $urandom % 5;
    hwr(2'h3, tgt);
    hwr(2'h1, 8'h00);
    run(8'h17, tgt, 5'h00);
    for (r = 3'h0; r < 3'h4; r = r + 3'h1) begin
      single_density = r[0];
      run(8'h50 | {6'h00, r[1:0]}, tgt + 8'h01, 5'h00);
      run(8'h70 | {6'h00, r[1:0]}, tgt, 5'h00);
      run(8'h20 | {6'h00, r[1:0]}, tgt, 5'h00);
      check({5'h00, drive.head}, {5'h00, tgt - 8'h01});
      run(8'h40 | {6'h00, r[1:0]}, tgt, 5'h00);
    end
    single_density = 1'b0;
    hwr(2'h2, 8'h02);
    exp_sec(4'h2);
    run(8'h84, tgt, 5'h01);
    hwr(2'h2, 8'h01);
    exp_sec(4'h1);
    exp_sec(4'h2);
    exp_sec(4'h3);
    run(8'h90, tgt, 5'h04);
    hwr(2'h2, 8'h09);
    run(8'h80, tgt, 5'h08);
    mode_wr = 1'b1;
    data_q.push_back(13'h010C);
    repeat (4) begin
      k = $urandom;
      wr_src.push_back(k);
      data_q.push_back({5'h00, k});
    end
    hwr(2'h2, 8'h04);
    run(8'hA1, tgt, 5'h00);
    host_on = 1'b0;
    hwr(2'h2, 8'h01);
    run(8'hA0, tgt, 5'h02);
    check({12'h000, data_q.size() == 0 && end_q.size() == 0}, 13'h0001);
    wrap_up;
  end
endmodule // test_floppy_seek_and_sector_sequencer
